/* File: sim/pcm_power_ctrl_asserts.sv */
`timescale 1ns/1ps
module pcm_power_ctrl_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input pcm_pkg::pcm_sfr_req_t sfr_req,
  input pcm_pkg::pcm_bit_req_t bit_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rvalid,
  input wire logic instr_end,
  input wire logic wdt_enabled,
  input wire logic [7:0] power_control,
  input wire logic baud_rate_doubler,
  input wire logic general_flag_zero,
  input wire logic general_flag_one,
  input wire logic cpu_hold,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic core_reset,
  input wire logic sfr_reset,
  input wire logic wake_irq,
  input wire logic stop_refused,
  input wire logic mode_idle,
  input wire logic mode_stop
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic run;
  logic wr87;
  assign run = !mode_idle && !mode_stop;
  assign wr87 = run && sfr_req.wr && sfr_req.addr == 8'h87 && !bit_req.wr && instr_end;
  read_answer_a: assert property (
    sfr_req.rd && sfr_req.addr == 8'h87 && !sfr_req.wr && !bit_req.wr
    |=> sfr_rvalid && sfr_rdata == $past(power_control)) else $error("read answer wrong");
  idle_entry_a: assert property (
    wr87 && sfr_req.wdata[1:0] == 2'b01 |=> mode_idle && !cpu_clk_en && periph_clk_en)
    else $error("idle entry wrong");
  stop_priority_a: assert property (
    wr87 && sfr_req.wdata[1] && !wdt_enabled |=> mode_stop && !mode_idle && !periph_clk_en)
    else $error("stop entry wrong");
  stop_refusal_a: assert property (
    wr87 && sfr_req.wdata[1] && wdt_enabled |=> stop_refused && !mode_stop && !power_control[1])
    else $error("stop not refused");
  idle_hold_a: assert property (mode_idle |-> cpu_hold && !cpu_clk_en)
    else $error("cpu not held in idle");
  wake_clear_a: assert property (
    $rose(wake_irq) |-> !mode_idle && !power_control[0] ##1 !wake_irq)
    else $error("wake did not clear idle");
  field_decode_a: assert property (
    baud_rate_doubler == power_control[7] && general_flag_zero == power_control[2]
    && general_flag_one == power_control[3] && power_control[6:4] == 3'h0)
    else $error("field decode wrong");
  reset_clear_a: assert property (
    core_reset |-> power_control == 8'h00 && run && sfr_reset) else $error("reset left mode");
  cover property ($rose(mode_idle));
  cover property (wake_irq);
  cover property (stop_refused);
  cover property (mode_stop ##1 !mode_stop);
endmodule

bind pcm_power_ctrl pcm_power_ctrl_asserts chk (.clk, .sys_rst, .sfr_req, .bit_req,
  .sfr_rdata, .sfr_rvalid, .instr_end, .wdt_enabled, .power_control, .baud_rate_doubler,
  .general_flag_zero, .general_flag_one, .cpu_hold, .cpu_clk_en, .periph_clk_en,
  .core_reset, .sfr_reset, .wake_irq, .stop_refused, .mode_idle, .mode_stop);

/* File: sim/tb_power_saving_mode_control.sv */
`timescale 1ns/1ps
module tb_power_saving_mode_control;
  logic clk = 0;
  logic sys_rst = 1;
  logic instr_end = 0;
  logic in_service_low = 0;
  logic in_service_high = 0;
  logic ext_reset_pin = 0;
  logic wdt_enabled = 0;
  logic wdt_overflow = 0;
  logic [7:0] irq_pend = 8'h00;
  logic [7:0] irq_high = 8'h00;
  pcm_pkg::pcm_sfr_req_t sq = '0;
  pcm_pkg::pcm_bit_req_t bq = '0;
  logic [7:0] sfr_rdata, power_control;
  logic sfr_rvalid, baud_rate_doubler, general_flag_zero, general_flag_one, cpu_hold;
  logic cpu_clk_en, periph_clk_en, osc_en, core_reset, sfr_reset, wake_irq, stop_refused;
  logic mode_idle, mode_stop;
  int failures = 0;
  int compares = 0;
  wire [7:0] st = {2'b00, cpu_clk_en, periph_clk_en, osc_en, cpu_hold, mode_idle, mode_stop};

  always #12.5 clk = ~clk;

  pcm_power_ctrl #(.NUM_IRQ(8), .HOLD_CLKS(pcm_pkg::RESET_HOLD_CLKS)) dut (.clk(clk),
    .sys_rst(sys_rst),
    .sfr_req(sq), .bit_req(bq), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
    .instr_end(instr_end), .irq_pend(irq_pend), .irq_high(irq_high),
    .in_service_low(in_service_low), .in_service_high(in_service_high),
    .ext_reset_pin(ext_reset_pin), .wdt_enabled(wdt_enabled), .wdt_overflow(wdt_overflow),
    .power_control(power_control), .baud_rate_doubler(baud_rate_doubler),
    .general_flag_zero(general_flag_zero), .general_flag_one(general_flag_one),
    .cpu_hold(cpu_hold), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .osc_en(osc_en), .core_reset(core_reset), .sfr_reset(sfr_reset), .wake_irq(wake_irq),
    .stop_refused(stop_refused), .mode_idle(mode_idle), .mode_stop(mode_stop));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] d, input logic ie);
    sq = '{1'b1, 1'b0, 8'h87, d};
    instr_end = ie;
    @(negedge clk);
    sq = '0;
    instr_end = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp, input logic v);
    sq = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    sq = '0;
    chk({7'h0, sfr_rvalid}, {7'h0, v});
    chk(sfr_rdata, exp);
  endtask
  task bitw(input logic [2:0] i, input logic val);
    bq = '{1'b1, 8'h87, i, val};
    @(negedge clk);
    bq = '0;
  endtask
  function logic pick(input int k);
    case (k)
      0: return mode_idle;
      1: return mode_stop;
      2: return wake_irq;
      default: return core_reset;
    endcase
  endfunction
  task wt(input int k, input logic v);
    int n;
    n = 0;
    while (pick(k) !== v && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (pick(k) !== v) begin
      failures++;
      $display("ERROR %0t wait ran out", $time);
      give_verdict;
    end
  endtask
  task pulse_wdt;
    wdt_overflow = 1;
    @(negedge clk);
    wdt_overflow = 0;
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    sys_rst = 0;
    chk(st, 8'h38);
    rd(8'h87, 8'h00, 1);
    rd(8'h86, 8'h00, 0);
    $display("test reset done");
    wr(8'hfc, 0);
    rd(8'h87, 8'h8c, 1);
    chk({5'h0, baud_rate_doubler, general_flag_one, general_flag_zero}, 8'h07);
    bitw(3'h2, 0);
    rd(8'h87, 8'h88, 1);
    $display("test register done");
    wr(8'h89, 1);
    chk(st, 8'h1e);
    wr(8'h00, 0);
    rd(8'h87, 8'h89, 1);
    in_service_high = 1;
    irq_pend = 8'h01;
    repeat (4) @(negedge clk);
    chk(st, 8'h1e);
    in_service_high = 0;
    in_service_low = 1;
    irq_high = 8'h01;
    wt(2, 1);
    chk(st, 8'h38);
    irq_pend = 8'h00;
    in_service_low = 0;
    rd(8'h87, 8'h88, 1);
    chk(power_control, 8'h88);
    $display("test idle done");
    wdt_enabled = 1;
    wr(8'h02, 1);
    chk({7'h0, stop_refused}, 8'h01);
    rd(8'h87, 8'h00, 1);
    wdt_enabled = 0;
    wr(8'h03, 1);
    chk(st, 8'h05);
    irq_pend = 8'hff;
    pulse_wdt;
    repeat (4) @(negedge clk);
    chk(st, 8'h05);
    chk(power_control, 8'h03);
    irq_pend = 8'h00;
    ext_reset_pin = 1;
    repeat (5) @(negedge clk);
    chk({6'h0, osc_en, mode_stop}, 8'h03);
    wt(1, 0);
    wt(3, 1);
    chk({7'h0, sfr_reset}, 8'h01);
    chk(power_control, 8'h00);
    repeat (8) @(negedge clk);
    chk({6'h0, osc_en, core_reset}, 8'h03);
    ext_reset_pin = 0;
    repeat (12) @(negedge clk);
    rd(8'h87, 8'h00, 1);
    $display("test stop done");
    wr(8'h81, 1);
    pulse_wdt;
    wt(0, 0);
    repeat (4) @(negedge clk);
    rd(8'h87, 8'h00, 1);
    wr(8'h01, 1);
    ext_reset_pin = 1;
    repeat (12) @(negedge clk);
    chk(st, 8'h1e);
    wt(0, 0);
    ext_reset_pin = 0;
    $display("test exit done");
    give_verdict;
  end
endmodule

/* File: src/pcm_pkg.sv */
package pcm_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] POWER_CONTROL_WMASK = 8'h8f;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int IDLE_SELECT_POS = 0;
  localparam int STOP_SELECT_POS = 1;
  localparam int GENERAL_FLAG_ZERO_POS = 2;
  localparam int GENERAL_FLAG_ONE_POS = 3;
  localparam int BAUD_RATE_DOUBLER_POS = 7;

  // ---------------------------------------------------------------
  // Cycle counts
  // ---------------------------------------------------------------
  localparam int INSTR_CYCLE_CLKS = 4;
  localparam int RESET_HOLD_INSTR = 2;
  localparam int RESET_HOLD_CLKS = INSTR_CYCLE_CLKS * RESET_HOLD_INSTR;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PCM_RUN,
    PCM_IDLE,
    PCM_STOP
  } pcm_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcm_sfr_req_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [2:0] idx;
    logic val;
  } pcm_bit_req_t;

endpackage

/* File: src/pcm_power_ctrl.sv */
`timescale 1ns/1ps
module pcm_power_ctrl #(
  parameter int NUM_IRQ = 8,
  parameter int HOLD_CLKS = pcm_pkg::RESET_HOLD_CLKS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input pcm_pkg::pcm_sfr_req_t sfr_req,
  input pcm_pkg::pcm_bit_req_t bit_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  input wire logic instr_end,
  input wire logic [NUM_IRQ-1:0] irq_pend,
  input wire logic [NUM_IRQ-1:0] irq_high,
  input wire logic in_service_low,
  input wire logic in_service_high,
  input wire logic ext_reset_pin,
  input wire logic wdt_enabled,
  input wire logic wdt_overflow,
  output logic [7:0] power_control,
  output logic baud_rate_doubler,
  output logic general_flag_zero,
  output logic general_flag_one,
  output logic cpu_hold,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_en,
  output logic core_reset,
  output logic sfr_reset,
  output logic wake_irq,
  output logic stop_refused,
  output logic mode_idle,
  output logic mode_stop
);

  // ---------------------------------------------------------------
  // Address and state decode
  // ---------------------------------------------------------------
  function automatic logic hits_power_control(input logic [7:0] addr);
    hits_power_control = (addr == pcm_pkg::POWER_CONTROL_ADDR);
  endfunction

  function automatic logic is_running(input pcm_pkg::pcm_state_t mode);
    is_running = (mode == pcm_pkg::PCM_RUN);
  endfunction

  function automatic logic is_stopped(input pcm_pkg::pcm_state_t mode);
    is_stopped = (mode == pcm_pkg::PCM_STOP);
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  pcm_pkg::pcm_state_t state, next_state;
  logic [7:0] next_power_control;
  logic [7:0] after_write;
  logic [7:0] bit_mask;
  logic [7:0] sw_data;
  logic [7:0] next_sfr_rdata;
  logic next_sfr_rvalid;
  logic next_core_reset;
  logic next_sfr_reset;
  logic next_wake_irq;
  logic next_stop_refused;
  logic byte_write;
  logic one_bit_write;
  logic ext_pin_seen;
  logic ext_reset_req;
  logic wake_req;
  logic wdt_reset_req;
  logic any_reset;
  logic enter_now;
  logic want_stop;
  logic want_idle;

  // ---------------------------------------------------------------
  // External reset pin filter
  // ---------------------------------------------------------------
  // two instruction cycles
  pcm_rst_filter #(
    .HOLD_CLKS(HOLD_CLKS)
  ) u_rst_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_level(ext_reset_pin),
    .pin_seen(ext_pin_seen),
    .hold_done(ext_reset_req)
  );

  // ---------------------------------------------------------------
  // Interrupt wake arbitration
  // ---------------------------------------------------------------
  // priority-gated wake
  pcm_wake_arb #(
    .NUM_IRQ(NUM_IRQ)
  ) u_wake_arb (
    .irq_pend(irq_pend),
    .irq_high(irq_high),
    .in_service_low(in_service_low),
    .in_service_high(in_service_high),
    .wake(wake_req)
  );

  // ---------------------------------------------------------------
  // Software access to the power control register
  // ---------------------------------------------------------------
  always_comb begin
    byte_write = sfr_req.wr && hits_power_control(sfr_req.addr);
    one_bit_write = bit_req.wr && hits_power_control(bit_req.addr);
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit_lane
      always_comb begin
        bit_mask[gi] = one_bit_write && (bit_req.idx == 3'(gi));
      end
    end
  endgenerate

  always_comb begin
    sw_data = power_control;
    if (byte_write) begin
      sw_data = sfr_req.wdata;
    end
    if (one_bit_write) begin
      sw_data = (power_control & ~bit_mask) | ({8{bit_req.val}} & bit_mask);
    end
    after_write = (power_control & ~pcm_pkg::POWER_CONTROL_WMASK)
      | (sw_data & pcm_pkg::POWER_CONTROL_WMASK);
    // Halted core issues no writes
    if (!is_running(state)) begin
      after_write = power_control;
    end
  end

  // ---------------------------------------------------------------
  // Reset sources
  // ---------------------------------------------------------------
  always_comb begin
    wdt_reset_req = wdt_overflow && !is_stopped(state);
    any_reset = ext_reset_req || wdt_reset_req;
  end

  // ---------------------------------------------------------------
  // Mode entry decision
  // ---------------------------------------------------------------
  always_comb begin
    want_stop = after_write[pcm_pkg::STOP_SELECT_POS];
    want_idle = after_write[pcm_pkg::IDLE_SELECT_POS] && !want_stop;
    enter_now = is_running(state) && instr_end && !any_reset
      && (want_stop || after_write[pcm_pkg::IDLE_SELECT_POS]);
  end

  // ---------------------------------------------------------------
  // Mode state machine and register next values
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_power_control = after_write;
    case (state)
      pcm_pkg::PCM_RUN: begin
        if (enter_now) begin
          if (want_stop && wdt_enabled) begin
            next_power_control[pcm_pkg::STOP_SELECT_POS] = 1'b0;
            if (after_write[pcm_pkg::IDLE_SELECT_POS]) begin
              next_state = pcm_pkg::PCM_IDLE;
            end
          end else if (want_stop) begin
            next_state = pcm_pkg::PCM_STOP;
          end else if (want_idle) begin
            next_state = pcm_pkg::PCM_IDLE;
          end
        end
      end
      pcm_pkg::PCM_IDLE: begin
        if (any_reset) begin
          next_state = pcm_pkg::PCM_RUN;
        end else if (wake_req) begin
          next_power_control[pcm_pkg::IDLE_SELECT_POS] = 1'b0;
          next_state = pcm_pkg::PCM_RUN;
        end
      end
      pcm_pkg::PCM_STOP: begin
        if (ext_reset_req) begin
          next_state = pcm_pkg::PCM_RUN;
        end
      end
      default: begin
        next_state = pcm_pkg::PCM_RUN;
      end
    endcase
    if (any_reset) begin
      next_power_control = pcm_pkg::POWER_CONTROL_RESET;
    end
  end

  // ---------------------------------------------------------------
  // Status pulses
  // ---------------------------------------------------------------
  always_comb begin
    next_core_reset = any_reset;
    next_sfr_reset = any_reset;
    next_stop_refused = enter_now && want_stop && wdt_enabled;
    next_wake_irq = (state == pcm_pkg::PCM_IDLE) && !any_reset && wake_req;
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    next_sfr_rvalid = sfr_req.rd && hits_power_control(sfr_req.addr);
    next_sfr_rdata = 8'h00;
    if (next_sfr_rvalid) begin
      next_sfr_rdata = power_control & pcm_pkg::POWER_CONTROL_WMASK;
    end
  end

  // ---------------------------------------------------------------
  // Mode registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= pcm_pkg::PCM_RUN;
      power_control <= pcm_pkg::POWER_CONTROL_RESET;
    end else begin
      state <= next_state;
      power_control <= next_power_control;
    end
  end

  // ---------------------------------------------------------------
  // Pulse registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_reset <= 1'b0;
      sfr_reset <= 1'b0;
      wake_irq <= 1'b0;
      stop_refused <= 1'b0;
    end else begin
      core_reset <= next_core_reset;
      sfr_reset <= next_sfr_reset;
      wake_irq <= next_wake_irq;
      stop_refused <= next_stop_refused;
    end
  end

  // ---------------------------------------------------------------
  // Read registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
      sfr_rvalid <= 1'b0;
    end else begin
      sfr_rdata <= next_sfr_rdata;
      sfr_rvalid <= next_sfr_rvalid;
    end
  end

  // ---------------------------------------------------------------
  // Clock and control outputs
  // ---------------------------------------------------------------
  always_comb begin
    baud_rate_doubler = power_control[pcm_pkg::BAUD_RATE_DOUBLER_POS];
    general_flag_zero = power_control[pcm_pkg::GENERAL_FLAG_ZERO_POS];
    general_flag_one = power_control[pcm_pkg::GENERAL_FLAG_ONE_POS];
    mode_idle = (state == pcm_pkg::PCM_IDLE);
    mode_stop = is_stopped(state);
    cpu_hold = !is_running(state) || enter_now;
    cpu_clk_en = is_running(state);
    periph_clk_en = !is_stopped(state);
    // stays on while reset is held
    osc_en = !is_stopped(state) || ext_pin_seen;
  end

endmodule

/* File: src/pcm_rst_filter.sv */
`timescale 1ns/1ps
module pcm_rst_filter #(
  parameter int HOLD_CLKS = pcm_pkg::RESET_HOLD_CLKS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin_level,
  output logic pin_seen,
  output logic hold_done
);

  // ---------------------------------------------------------------
  // Three-stage synchroniser and hold counter
  // ---------------------------------------------------------------
  logic sync_a, sync_b, sync_c;
  logic next_pin_seen;
  logic [7:0] hold_cnt, next_hold_cnt;

  always_comb begin
    next_pin_seen = pin_seen;
    if (sync_b == sync_c) begin
      next_pin_seen = sync_c;
    end
    next_hold_cnt = 8'h00;
    if (pin_seen) begin
      next_hold_cnt = (hold_cnt == 8'(HOLD_CLKS)) ? hold_cnt : hold_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
      pin_seen <= 1'b0;
      hold_cnt <= 8'h00;
    end else begin
      sync_a <= pin_level;
      sync_b <= sync_a;
      sync_c <= sync_b;
      pin_seen <= next_pin_seen;
      hold_cnt <= next_hold_cnt;
    end
  end

  assign hold_done = (hold_cnt == 8'(HOLD_CLKS));

endmodule

/* File: src/pcm_wake_arb.sv */
`timescale 1ns/1ps
module pcm_wake_arb #(
  parameter int NUM_IRQ = 8
) (
  input wire logic [NUM_IRQ-1:0] irq_pend,
  input wire logic [NUM_IRQ-1:0] irq_high,
  input wire logic in_service_low,
  input wire logic in_service_high,
  output logic wake
);

  // ---------------------------------------------------------------
  // Wake only above the level now in service
  // ---------------------------------------------------------------
  logic any_high, any_low;

  always_comb begin
    any_high = |(irq_pend & irq_high);
    any_low = |(irq_pend & ~irq_high);
    wake = (any_high && !in_service_high)
      || (any_low && !in_service_low && !in_service_high);
  end

endmodule
